// file: hdl/blw_pkg.sv
// Contract
// - x18: both selects low write 18 bits
// - x18: select 0 gates [8:0], 1 gates [17:9]
// - All selects high leaves word unchanged
// - x36: four selects low write 36 bits
// - x36: select 0 alone writes only [8:0]
// - x36: selects 1..3 gate their own lanes
// - Beat 0 on K rise, beat 1 on K_N
// - Each beat uses its own lane pattern
// - Power-up deselected, read outputs high impedance
// - First word at A, second at A+1
// - Read data launched on output clock rises
package blw_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int LANE_W = 9;          // Bits per lane
  localparam int X18_WIDTH = 18;      // Default word width
  localparam int X18_ADDR_W = 21;     // Default word address width
  localparam int SYNC_STAGES = 3;     // Pin synchroniser depth
  localparam int STRAP_WAIT = 4;      // Strap samples; only the last one sees the pins
  localparam int BUF_DEPTH = 2;       // Entries in the write buffer

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_Q_OE_N = 1'b1;     // Read bus released
  localparam logic RST_WR_READY = 1'b0;   // Not ready until reset ends

  // Write capture sequence
  typedef enum logic [0:0] {BLW_WR_IDLE, BLW_WR_BEAT1} blw_wr_e;
  // Read launch sequence
  typedef enum logic [1:0] {BLW_RD_IDLE, BLW_RD_WORD0, BLW_RD_WORD1, BLW_RD_HOLD} blw_rd_e;
endpackage : blw_pkg

// file: hdl/blw_stream_if.sv
// Valid/ready carrier between the capture logic, the buffer and the array
interface blw_stream_if #(
  parameter int W = 8
) (
  input wire logic clk
);
  logic valid;          // Word offered
  logic ready;          // Word accepted when valid is also high
  logic [W-1:0] data;   // Packed burst
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface : blw_stream_if

// file: hdl/blw_buf2.sv
// Two-entry buffer; a stalled drain fills it and drops ready
module blw_buf2 #(
  parameter int W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  blw_stream_if.rx in_s,
  blw_stream_if.tx out_s
);
  import blw_pkg::*;
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [W-1:0] ent_q [BUF_DEPTH];   // Entry array
  logic wr_ptr_q;                    // Next slot to fill
  logic rd_ptr_q;                    // Oldest slot
  logic [1:0] cnt_q;                 // Entries held
  logic push;
  logic pop;

  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  // Honest full and empty
  assign in_s.ready = (cnt_q != 2'(BUF_DEPTH));
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data = ent_q[rd_ptr_q];

  // Entry write; data needs no reset
  always_ff @(posedge CLK) begin
    if (CE && push) begin
      ent_q[wr_ptr_q] <= in_s.data;
    end
  end

  // Pointers and count
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (CE) begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule : blw_buf2

// file: hdl/blw_sram.sv
// Separate-I/O burst SRAM core with per-lane write masking
module blw_sram #(
  parameter int WIDTH = blw_pkg::X18_WIDTH,
  parameter int ADDR_W = blw_pkg::X18_ADDR_W,
  parameter int LANES = WIDTH / blw_pkg::LANE_W
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic K,
  input wire logic K_N,
  input wire logic C,
  input wire logic C_N,
  input wire logic READ_PORT_SEL_N,
  input wire logic WRITE_PORT_SEL_N,
  input wire logic [ADDR_W-1:0] A,
  input wire logic [WIDTH-1:0] D,
  input wire logic [LANES-1:0] LANE_WRITE_SELECT_N,
  output logic [WIDTH-1:0] Q,
  output logic Q_OE_N,
  output logic WR_READY
);
  import blw_pkg::*;

  localparam int PINS = 6 + ADDR_W + WIDTH + LANES;
  localparam int PW = ADDR_W + 4 * WIDTH;
  // Clocks high and selects off, so a reset stage never looks like an edge or a request
  localparam logic [PINS-1:0] SYNC_RST = {6'h3f, {(PINS-6){1'b0}}};

  // ----------------------------------------
  // Lane decode
  // ----------------------------------------
  // Expands active-low lane selects into a bit mask, one lane per select
  function automatic logic [WIDTH-1:0] lane_mask(input logic [LANES-1:0] sel_n);
    logic [WIDTH-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{~sel_n[i]}};
    end
    return m;
  endfunction : lane_mask

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic [PINS-1:0] s1_q;   // First stage, read only by s2_q
  logic [PINS-1:0] s2_q;
  logic [PINS-1:0] s3_q;
  logic [3:0] clk_f_q;     // Filtered K, K_N, C, C_N
  logic [3:0] agree;
  logic [3:0] rise;
  logic k_rise;
  logic k_n_rise;
  logic c_rise;
  logic c_n_rise;
  logic s_rps_n;
  logic s_wps_n;
  logic [ADDR_W-1:0] s_a;
  logic [WIDTH-1:0] s_d;
  logic [LANES-1:0] s_sel_n;

  // All pins share the same depth so data stays aligned with its clock edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else if (CE) begin
      s1_q <= {K, K_N, C, C_N, READ_PORT_SEL_N, WRITE_PORT_SEL_N, A, D,
               LANE_WRITE_SELECT_N};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign {s_rps_n, s_wps_n, s_a, s_d, s_sel_n} = s3_q[PINS-5:0];
  // A clock change counts only once stages two and three agree
  assign agree = ~(s2_q[PINS-1 -: 4] ^ s3_q[PINS-1 -: 4]);
  assign rise = agree & s3_q[PINS-1 -: 4] & ~clk_f_q;
  assign {k_rise, k_n_rise, c_rise, c_n_rise} = rise;

  // Filtered clock levels
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      clk_f_q <= 4'hf;
    end else if (CE) begin
      clk_f_q <= (clk_f_q & ~agree) | (s3_q[PINS-1 -: 4] & agree);
    end
  end

  // ----------------------------------------
  // Single clock strap
  // ----------------------------------------
  logic [2:0] strap_cnt_q;  // Waits for the synchroniser to fill
  logic single_clk_q;       // Output clocks tied high: K pair times outputs
  logic oclk_rise0;
  logic oclk_rise1;

  // Caught after reset release, then frozen until the next reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      strap_cnt_q <= 3'h0;
      single_clk_q <= 1'b0;
    end else if (CE && strap_cnt_q != 3'(STRAP_WAIT)) begin
      // Pins reach the third stage on the third edge, so only the fourth sample sees them; earlier samples are reset values
      strap_cnt_q <= strap_cnt_q + 3'h1;
      single_clk_q <= s3_q[PINS-3] & s3_q[PINS-4];
    end
  end

  assign oclk_rise0 = single_clk_q ? k_n_rise : c_n_rise;
  assign oclk_rise1 = single_clk_q ? k_rise : c_rise;

  // ----------------------------------------
  // Write capture
  // ----------------------------------------
  blw_stream_if #(.W(PW)) in_s (.clk(CLK));
  blw_stream_if #(.W(PW)) out_s (.clk(CLK));
  blw_wr_e wr_st_q;              // Capture sequence
  logic [WIDTH-1:0] d0_q;        // Beat 0 word
  logic [WIDTH-1:0] m0_q;        // Beat 0 mask
  logic push_q;                  // One-cycle push strobe
  logic [PW-1:0] burst_q;        // Packed burst for the buffer

  assign in_s.valid = push_q;
  assign in_s.data = burst_q;

  // A new write is refused while the buffer is full: the pins cannot stall
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_st_q <= BLW_WR_IDLE;
      d0_q <= '0;
      m0_q <= '0;
      push_q <= 1'b0;
      burst_q <= '0;
    end else if (CE) begin
      push_q <= 1'b0;
      case (wr_st_q)
        BLW_WR_IDLE: begin
          if (k_rise && !s_wps_n && in_s.ready) begin
            d0_q <= s_d;
            m0_q <= lane_mask(s_sel_n);
            wr_st_q <= BLW_WR_BEAT1;
          end
        end
        BLW_WR_BEAT1: begin
          // Beat 1 keeps its own mask
          if (k_n_rise) begin
            burst_q <= {s_a, lane_mask(s_sel_n), s_d, m0_q, d0_q};
            push_q <= 1'b1;
            wr_st_q <= BLW_WR_IDLE;
          end
        end
        default: wr_st_q <= BLW_WR_IDLE;
      endcase
    end
  end

  // Ready shown at the pins, registered
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      WR_READY <= RST_WR_READY;
    end else if (CE) begin
      WR_READY <= in_s.ready;
    end
  end

  blw_buf2 #(.W(PW)) u_buf (
    .CLK(CLK),
    .RST_N(RST_N),
    .CE(CE),
    .in_s(in_s),
    .out_s(out_s)
  );

  // ----------------------------------------
  // Array commit
  // ----------------------------------------
  logic [WIDTH-1:0] mem [2**ADDR_W];  // Storage array
  logic drain_hi_q;                   // Second word of the burst in flight
  logic [ADDR_W-1:0] o_a;
  logic [WIDTH-1:0] o_d1;
  logic [WIDTH-1:0] o_m1;
  logic [WIDTH-1:0] o_d0;
  logic [WIDTH-1:0] o_m0;
  logic [ADDR_W-1:0] mem_addr;
  logic [WIDTH-1:0] cur_d;
  logic [WIDTH-1:0] cur_m;
  logic commit;

  assign {o_a, o_m1, o_d1, o_m0, o_d0} = out_s.data;
  assign mem_addr = drain_hi_q ? o_a + ADDR_W'(1) : o_a;
  assign cur_d = drain_hi_q ? o_d1 : o_d0;
  assign cur_m = drain_hi_q ? o_m1 : o_m0;
  assign commit = CE && out_s.valid;
  // Pop only once both words are in the array
  assign out_s.ready = drain_hi_q;

  always_ff @(posedge CLK) begin
    if (commit) begin
      mem[mem_addr] <= (mem[mem_addr] & ~cur_m) | (cur_d & cur_m);
    end
  end

  // Word select toggles once per committed word
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      drain_hi_q <= 1'b0;
    end else if (commit) begin
      drain_hi_q <= ~drain_hi_q;
    end
  end

  // ----------------------------------------
  // Read launch
  // ----------------------------------------
  blw_rd_e rd_st_q;             // Launch sequence
  logic [ADDR_W-1:0] rd_a_q;    // Latched read address
  logic rd_pend_q;              // A read awaits its first launch edge

  // No forwarding: a read sees the array as committed so far
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_st_q <= BLW_RD_IDLE;
      rd_a_q <= '0;
      rd_pend_q <= 1'b0;
      Q <= '0;
      Q_OE_N <= RST_Q_OE_N;
    end else if (CE) begin
      if (k_rise && !s_rps_n) begin
        rd_a_q <= s_a;
        rd_pend_q <= 1'b1;
      end
      case (rd_st_q)
        BLW_RD_IDLE, BLW_RD_HOLD: begin
          // Word 0 on the first output clock rise
          if (oclk_rise0 && rd_pend_q) begin
            Q <= mem[rd_a_q];
            Q_OE_N <= 1'b0;
            rd_pend_q <= k_rise && !s_rps_n;
            rd_st_q <= BLW_RD_WORD1;
          end else if (oclk_rise0 || oclk_rise1) begin
            Q_OE_N <= 1'b1;
            rd_st_q <= BLW_RD_IDLE;
          end
        end
        BLW_RD_WORD1: begin
          if (oclk_rise1) begin
            Q <= mem[rd_a_q + ADDR_W'(1)];
            rd_st_q <= BLW_RD_HOLD;
          end
        end
        default: rd_st_q <= BLW_RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic chk_q;                   // A word was committed last cycle
  logic [ADDR_W-1:0] chk_a_q;
  logic [WIDTH-1:0] chk_d_q;
  logic [WIDTH-1:0] chk_m_q;
  logic [WIDTH-1:0] chk_old_q;

  // Snapshot of each commit for the checks below
  always_ff @(posedge CLK) begin
    chk_q <= RST_N && commit;
    chk_a_q <= mem_addr;
    chk_d_q <= cur_d;
    chk_m_q <= cur_m;
    chk_old_q <= mem[mem_addr];
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_full_word_write: assert property (
    chk_q && chk_m_q == '1 |-> mem[chk_a_q] == chk_d_q)
    else $error("full word not stored");
  a_lane_keep: assert property (
    chk_q |-> (mem[chk_a_q] & ~chk_m_q) == (chk_old_q & ~chk_m_q))
    else $error("deselected lane altered");
  a_no_lane_hold: assert property (
    chk_q && chk_m_q == '0 |-> mem[chk_a_q] == chk_old_q)
    else $error("word changed with all lanes off");
  a_lane_store: assert property (
    chk_q |-> (mem[chk_a_q] & chk_m_q) == (chk_d_q & chk_m_q))
    else $error("selected lane not stored");
  a_beat0_capture: assert property (
    wr_st_q == BLW_WR_IDLE && k_rise && !s_wps_n && in_s.ready
    |=> d0_q == $past(s_d) && m0_q == lane_mask($past(s_sel_n)))
    else $error("beat 0 not captured on K");
  // Beat 1 mask must come from the selects seen at the K_N rise, not from beat 0
  a_beat1_mask: assert property (
    push_q |-> burst_q[3*WIDTH +: WIDTH] == lane_mask($past(s_sel_n)))
    else $error("beat 1 used wrong mask");
  // Second word lands one address above the first, one cycle later
  a_burst_order: assert property (
    commit && drain_hi_q |-> mem_addr == $past(mem_addr) + ADDR_W'(1))
    else $error("burst address order wrong");
  a_push_after_beat1: assert property (
    push_q |-> $past(k_n_rise) && $past(wr_st_q == BLW_WR_BEAT1))
    else $error("burst pushed before beat 1");
  a_powerup_hiz: assert property (
    disable iff (1'b0) !RST_N |=> Q_OE_N && rd_st_q == BLW_RD_IDLE)
    else $error("read bus driven after reset");
  a_launch_edge: assert property (
    $changed(Q) |-> $past(oclk_rise0 || oclk_rise1))
    else $error("read data moved off launch edge");

  c_masked_burst: cover property (chk_q && chk_m_q != '0 && chk_m_q != '1);
  c_buffer_full: cover property (!in_s.ready ##1 !WR_READY);
  c_read_burst: cover property (rd_st_q == BLW_RD_WORD1 ##[1:20] rd_st_q == BLW_RD_HOLD);
endmodule : blw_sram

// file: tb/blw_ctrl_model.sv
// Controller model: drives write and read bursts on the pin clock pair
module blw_ctrl_model #(
  parameter int W = 36,
  parameter int AW = 4,
  parameter int PH = 6
) (
  input wire logic clk,
  input wire logic [W-1:0] q,
  input wire logic q_oe_n,
  output logic k,
  output logic k_n,
  output logic wr_sel_n,
  output logic rd_sel_n,
  output logic [AW-1:0] a,
  output logic [W-1:0] d,
  output logic [W/9-1:0] lane_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Idle pins
  // ----------------------------------------
  // Clocks parked equal
  initial begin
    k = 1'b0;
    k_n = 1'b0;
    wr_sel_n = 1'b1;
    rd_sel_n = 1'b1;
    a = '0;
    d = '0;
    lane_n = '1;
  end

  // Settle pins, flip the clock pair, then hold it long enough for the synchroniser
  task automatic edge_k(input logic kv, input logic knv);
    repeat (3) @(negedge clk);
    k = kv;
    k_n = knv;
    repeat (PH) @(negedge clk);
  endtask : edge_k

  // Released pins show the inverse of the last value, not a kind leftover
  task automatic drop_pins();
    wr_sel_n = 1'b1;
    rd_sel_n = 1'b1;
    a = ~a;
    d = ~d;
    lane_n = ~lane_n;
  endtask : drop_pins

  // ----------------------------------------
  // Write burst
  // ----------------------------------------
  task automatic wr(input logic [AW-1:0] adr, input logic [W-1:0] d0, input logic [W-1:0] d1,
                    input logic [W/9-1:0] m0, input logic [W/9-1:0] m1);
    @(negedge clk);
    // Select at K, address at K_N
    wr_sel_n = 1'b0;
    d = d0;
    lane_n = m0;
    edge_k(1'b1, 1'b0);
    a = adr;
    d = d1;
    lane_n = m1;
    edge_k(1'b0, 1'b1);
    drop_pins();
    edge_k(1'b0, 1'b0);
  endtask : wr

  // ----------------------------------------
  // Read burst, single clock mode
  // ----------------------------------------
  task automatic rd(input logic [AW-1:0] adr, output logic [W-1:0] q0, output logic [W-1:0] q1,
                    output logic oe0, output logic oe1);
    @(negedge clk);
    rd_sel_n = 1'b0;
    a = adr;
    edge_k(1'b1, 1'b0);
    drop_pins();
    edge_k(1'b0, 1'b1);
    q0 = q;
    oe0 = q_oe_n;
    edge_k(1'b1, 1'b0);
    q1 = q;
    edge_k(1'b0, 1'b1);
    oe1 = q_oe_n;
    edge_k(1'b0, 1'b0);
  endtask : rd
endmodule : blw_ctrl_model

// file: tb/test_byte_lane_write_mask.sv
// Bench: random masked bursts against a reference array
module test_byte_lane_write_mask;
  timeunit 1ns;
  timeprecision 1ps;
  import blw_pkg::*;
  localparam int W = 36;
  localparam int AW = 4;
  localparam int L = W / LANE_W;
  logic clk;
  logic rst_n;
  logic k, k_n, wps_n, rps_n, q_oe_n, wr_ready;
  logic [AW-1:0] a;
  logic [W-1:0] d, q;
  logic [L-1:0] lane_n;
  int n_fail;
  int tests_run;
  logic [W-1:0] mem [1<<AW]; // Reference array
  logic [17:0] q18;          // Read data of the narrow part
  logic [W-1:0] mem18 [1<<AW]; // Reference for the narrow part, low 18 bits meaningful

  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Output clocks tied high: single clock strap, outputs timed by K
  blw_sram #(.WIDTH(W), .ADDR_W(AW)) dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .K(k),
    .K_N(k_n), .C(1'b1), .C_N(1'b1), .READ_PORT_SEL_N(rps_n), .WRITE_PORT_SEL_N(wps_n),
    .A(a), .D(d), .LANE_WRITE_SELECT_N(lane_n), .Q(q), .Q_OE_N(q_oe_n), .WR_READY(wr_ready));
  // Narrow part with output clocks on the K pair: low at reset, so the C-timed path runs
  blw_sram #(.WIDTH(18), .ADDR_W(AW)) dut_x18 (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .K(k),
    .K_N(k_n), .C(k), .C_N(k_n), .READ_PORT_SEL_N(rps_n), .WRITE_PORT_SEL_N(wps_n),
    .A(a), .D(d[17:0]), .LANE_WRITE_SELECT_N(lane_n[1:0]), .Q(q18), .Q_OE_N(), .WR_READY());
  blw_ctrl_model #(.W(W), .AW(AW), .PH(6)) ctrl (.clk(clk), .q(q), .q_oe_n(q_oe_n), .k(k),
    .k_n(k_n), .wr_sel_n(wps_n), .rd_sel_n(rps_n), .a(a), .d(d), .lane_n(lane_n));

  // ----------------------------------------
  // Reference and checks
  // ----------------------------------------
  // Only lanes whose select is low take new data
  function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [W-1:0] nw,
                                         input logic [L-1:0] sel_n);
    for (int i = 0; i < L; i++) begin
      if (!sel_n[i]) old[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
    end
    return old;
  endfunction : merge

  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Addresses kept below the top so A+1 never wraps
  task automatic do_wr(input logic [AW-1:0] adr, input logic [L-1:0] m0, input logic [L-1:0] m1);
    logic [W-1:0] d0, d1;
    d0 = W'({$urandom, $urandom});
    d1 = W'({$urandom, $urandom});
    ctrl.wr(adr, d0, d1, m0, m1);
    mem[adr] = merge(mem[adr], d0, m0);
    mem[AW'(adr + 1'b1)] = merge(mem[AW'(adr + 1'b1)], d1, m1);
    // Narrow part sees only the two low selects of each beat
    mem18[adr] = merge(mem18[adr], d0, {2'b11, m0[1:0]});
    mem18[AW'(adr + 1'b1)] = merge(mem18[AW'(adr + 1'b1)], d1, {2'b11, m1[1:0]});
  endtask : do_wr

  task automatic do_rd(input logic [AW-1:0] adr);
    logic [W-1:0] q0, q1;
    logic oe0, oe1;
    ctrl.rd(adr, q0, q1, oe0, oe1);
    chk(q0, mem[adr]);
    chk(q1, mem[AW'(adr + 1'b1)]);
    chk(W'(oe0), W'(1'b0));
    chk(W'(oe1), W'(1'b1));
    // Narrow part still shows its second word after the burst
    chk(W'(q18), W'(mem18[AW'(adr + 1'b1)][17:0]));
  endtask : do_rd

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0;
    void'($urandom(52));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(W'(q_oe_n), W'(1'b1));
    chk(W'(wr_ready), W'(1'b1));
    // Full-lane fill so later partial writes merge with known contents
    for (int i = 0; i < 16; i += 2) do_wr(AW'(i), '0, '0);
    // Every first-beat pattern, random second beat, then a read at a random address
    for (int m = 0; m < 16; m++) begin
      do_wr(AW'($urandom_range(14, 0)), L'(m), L'($urandom));
      do_rd(AW'($urandom_range(14, 0)));
    end
    // Back-to-back bursts, then sweep the whole array
    for (int i = 0; i < 4; i++) do_wr(AW'($urandom_range(14, 0)), L'($urandom), L'($urandom));
    // Last read wraps to address zero in both the part and the reference
    for (int i = 0; i < 16; i++) do_rd(AW'(i));
    summarize();
  end

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    $display("[ERR] %0t timeout", $time);
    summarize();
  end
endmodule : test_byte_lane_write_mask
